// File: verif/pcc_properties.sv
// Port-level checks of the counter-compare unit.
`timescale 1ns/1ps
`default_nettype none
module pcc_props (
  input wire logic        clk, sys_rst, reg_rd, tb_enable, count_up,
  input wire logic [15:0] reg_rdata, timebase_count, period_value,
  input wire logic        match_a_event, match_b_event, zero_match_event,
  input wire logic        period_match_event, event_count_up
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_zero_evt: assert property (tb_enable && timebase_count == 16'h0 |=> zero_match_event)
    else $error("zero event missing");
  chk_zero_only: assert property (!(tb_enable && timebase_count == 16'h0) |=> !zero_match_event)
    else $error("spurious zero event");
  chk_prd_evt: assert property (tb_enable && timebase_count == period_value |=> period_match_event)
    else $error("period event missing");
  chk_prd_only: assert property (!(tb_enable && timebase_count == period_value) |=> !period_match_event)
    else $error("spurious period event");
  chk_a_idle: assert property (!tb_enable |=> !match_a_event)
    else $error("A event without tick");
  chk_b_idle: assert property (!tb_enable |=> !match_b_event)
    else $error("B event without tick");
  chk_dir_copy: assert property (tb_enable |=> event_count_up == $past(count_up))
    else $error("direction not carried");
  chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 16'h0)
    else $error("read data outside read slot");
endmodule // pcc_props
bind pcc_counter_compare pcc_props i_props (.clk, .sys_rst, .reg_rd, .tb_enable, .count_up,
  .reg_rdata, .timebase_count, .period_value, .match_a_event, .match_b_event,
  .zero_match_event, .period_match_event, .event_count_up);
`default_nettype wire

// File: verif/pcc_tb_model.sv
// Time-base counter model: mode 0 up, 1 down, 2 up-down.
`timescale 1ns/1ps
`default_nettype none
module pcc_tb_model (
  input wire logic        clk, sys_rst,
  input wire logic [1:0]  mode,
  input wire logic [15:0] prd,
  output logic     [15:0] cnt,
  output logic            up
);
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 16'h0;
      up <= 1'b1;
    end else if (mode == 2'h2) begin
      if (up && cnt >= prd) up <= 1'b0;
      if (!up && cnt == 16'h0) up <= 1'b1;
      cnt <= (up ? cnt < prd : cnt == 16'h0) ? cnt + 16'h1 : cnt - 16'h1;
    end else begin
      up <= (mode == 2'h0);
      cnt <= (mode == 2'h0) ? (cnt >= prd ? 16'h0 : cnt + 16'h1) : (cnt == 16'h0 ? prd : cnt - 16'h1);
    end
  end
endmodule // pcc_tb_model
`default_nettype wire

// File: verif/pwm_counter_compare_unit_bench.sv
// Register and event-count tests of the counter-compare unit.
`timescale 1ns/1ps
`default_nettype none
module pwm_counter_compare_unit_bench;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, tb_enable = 0, count_up;
  logic [7:0] reg_addr = 8'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, timebase_count, period_value = 16'h8;
  logic [1:0] mode = 2'h2;
  logic match_a_event, match_b_event, zero_match_event, period_match_event, event_count_up;
  int fails = 0, total_checks = 0, cyc = 0, na, nb;
  always #12.5 clk = !clk;
  pcc_tb_model i_tb (.clk, .sys_rst, .mode, .prd(period_value), .cnt(timebase_count), .up(count_up));
  pcc_counter_compare i_dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tb_enable, .timebase_count, .period_value, .count_up, .match_a_event, .match_b_event,
    .zero_match_event, .period_match_event, .event_count_up);
  task stop_test;
    if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) if (++cyc > 3000) begin fails++; stop_test; end
  task chk(input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin fails++; $display("[ERR] %0t got %h exp %h", $time, s, e); end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
    @(posedge clk); reg_wr <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk); reg_addr <= a; reg_rd <= 1;
    @(posedge clk); reg_rd <= 0;
    @(negedge clk); chk(reg_rdata, e);
  endtask
  // Event counts over one whole counter cycle hold for any starting phase.
  task run(input logic [1:0] m, input int n, ea, eb);
    @(posedge clk); mode <= m; tb_enable <= 1;
    repeat (20) @(posedge clk);
    na = 0; nb = 0;
    repeat (n) begin @(negedge clk); na += match_a_event; nb += match_b_event; end
    chk(16'(na), 16'(ea)); chk(16'(nb), 16'(eb));
  endtask
  initial begin
    repeat (2) @(posedge clk); sys_rst <= 0;
    rd(8'h1c, 16'h0);
    rd(8'h24, 16'h0);
    wr(8'h1c, 16'h0040); wr(8'h24, 16'h3); wr(8'h28, 16'h8);
    rd(8'h24, 16'h3);
    rd(8'h28, 16'h8);
    rd(8'h20, 16'h0);
    rd(8'h3c, 16'h0);
    run(2, 16, 2, 1);
    wr(8'h28, 16'h0); run(2, 16, 2, 1);
    run(0, 9, 1, 1); run(1, 9, 1, 1);
    wr(8'h1c, 16'h0043); wr(8'h24, 16'hff); run(2, 16, 2, 1);
    wr(8'h1c, 16'h0040); run(2, 16, 0, 1);
    wr(8'h1c, 16'h0041); wr(8'h24, 16'h5); run(2, 16, 2, 1);
    wr(8'h1c, 16'h0042); wr(8'h24, 16'h8); run(2, 16, 1, 1);
    stop_test;
  end
endmodule // pwm_counter_compare_unit_bench
`default_nettype wire

// File: verilog/pcc_counter_compare.v
// Counter-compare unit: two compare channels with shadowed compare values.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Compare counter to active values every clock.
// - Channels A and B fully independent.
// - Up or down mode: one event per period.
// - Up-down: twice inside range, once at ends.
// - Shadow shares address; access always goes to shadow.
// - Select clear enables shadow; reset enables both.
// - Shadow loads at zero, period, or both.
// - Only active values produce events.
// - Select bits 4, 6 write into load fields; select never set.
// - Events skipped by sync jumps are acceptable.
// - Events carry current counter direction.
// - Works in up, down and up-down modes.
// - Fine extension reads reserved without extension.
// - Up-down counter rises to period, falls.
`include "pcc_regs.vh"

module pcc_counter_compare #(
  parameter HAS_FINE = 0
) (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // Time base
  input  wire        tb_enable,
  input  wire [15:0] timebase_count,
  input  wire [15:0] period_value,
  input  wire        count_up,
  // Events to the action qualifier
  output reg         match_a_event,
  output reg         match_b_event,
  output reg         zero_match_event,
  output reg         period_match_event,
  output reg         event_count_up
);

  reg  [15:0] control_q;
  reg  [15:0] fine_a_q;
  reg  [15:0] active_q [0:1];
  reg  [15:0] shadow_q [0:1];
  reg  [1:0]  shadow_full_q;
  wire [5:0]  idx;
  wire        at_zero;
  wire        at_period;
  wire [1:0]  sel_active;
  wire [1:0]  load_now;
  wire [1:0]  match;

  assign idx       = reg_addr[7:2];
  assign at_zero   = timebase_count == `PCC_ZERO_COUNT;
  assign at_period = timebase_count == period_value;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_chan
      wire [1:0] lp;
      wire       wr_hit;
      assign lp = control_q[`PCC_LOAD_A_LSB + 2*g +: 2];
      assign sel_active[g] = control_q[`PCC_SHADOW_A_BIT + 2*g];
      assign wr_hit = reg_wr && (idx == {2'h0, `PCC_IDX_CMP_A} + g);
      assign load_now[g] = !sel_active[g] && tb_enable &&
        ((lp == `PCC_LOAD_ZERO   && at_zero) ||
         (lp == `PCC_LOAD_PERIOD && at_period) ||
         (lp == `PCC_LOAD_EITHER && (at_zero || at_period)));
      // Active copy only; the shadow never reaches the comparator.
      assign match[g] = timebase_count == active_q[g];

      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          active_q[g]      <= `PCC_COMPARE_RESET;
          shadow_q[g]      <= `PCC_COMPARE_RESET;
          shadow_full_q[g] <= 1'b0;
        end else begin
          if (wr_hit && sel_active[g]) begin
            active_q[g] <= reg_wdata;
          end else if (load_now[g]) begin
            active_q[g] <= shadow_q[g];
          end
          if (wr_hit && !sel_active[g]) begin
            shadow_q[g] <= reg_wdata;
          end
          // A write in the load cycle keeps the flag set for the next point.
          if (wr_hit && !sel_active[g]) begin
            shadow_full_q[g] <= 1'b1;
          end else if (load_now[g]) begin
            shadow_full_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Events fire once per time-base tick in which the counter holds the value.
  // In up or down mode the value is visited once per period; in up-down mode
  // it is passed twice unless it sits at zero or the period turning point.
  // A sync jump past a value simply yields no event.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      match_a_event      <= 1'b0;
      match_b_event      <= 1'b0;
      zero_match_event   <= 1'b0;
      period_match_event <= 1'b0;
      event_count_up     <= 1'b1;
    end else begin
      match_a_event      <= tb_enable && match[0];
      match_b_event      <= tb_enable && match[1];
      zero_match_event   <= tb_enable && at_zero;
      period_match_event <= tb_enable && at_period;
      event_count_up     <= count_up;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      control_q <= `PCC_CONTROL_RESET;
      fine_a_q  <= 16'h0000;
    end else if (reg_wr) begin
      if (idx == {2'h0, `PCC_IDX_CONTROL}) begin
        control_q <= {12'h000, reg_wdata[6], 1'b0, reg_wdata[4], 1'b0} |
                     {12'h000, reg_wdata[3:0]};
      end
      if (idx == {2'h0, `PCC_IDX_FINE_A} && HAS_FINE != 0) begin
        fine_a_q <= reg_wdata;
      end
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (idx)
        {2'h0, `PCC_IDX_CONTROL}: reg_rdata <= {6'h00, shadow_full_q, control_q[7:0]};
        {2'h0, `PCC_IDX_FINE_A}:  reg_rdata <= (HAS_FINE != 0) ? fine_a_q : 16'h0000;
        {2'h0, `PCC_IDX_CMP_A}:   reg_rdata <= sel_active[0] ? active_q[0] : shadow_q[0];
        {2'h0, `PCC_IDX_CMP_B}:   reg_rdata <= sel_active[1] ? active_q[1] : shadow_q[1];
        default:                  reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule // pcc_counter_compare
`default_nettype wire

// File: verilog/pcc_regs.vh
// Register offsets, field positions and reset values of the counter-compare unit.
`ifndef PCC_REGS_VH
`define PCC_REGS_VH

// Register word indices; the byte address is four times the index.
`define PCC_IDX_CONTROL      4'h7
`define PCC_IDX_FINE_A       4'h8
`define PCC_IDX_CMP_A        4'h9
`define PCC_IDX_CMP_B        4'ha
`define PCC_ADDR_W           8

// Control register field positions.
`define PCC_LOAD_A_LSB       0
`define PCC_LOAD_B_LSB       2
`define PCC_SHADOW_A_BIT     4
`define PCC_SHADOW_B_BIT     6
`define PCC_SHADOW_A_FULL    8
`define PCC_SHADOW_B_FULL    9

// Load-point encodings.
`define PCC_LOAD_ZERO        2'h0
`define PCC_LOAD_PERIOD      2'h1
`define PCC_LOAD_EITHER      2'h2
`define PCC_LOAD_NONE        2'h3

// Reset values.
`define PCC_CONTROL_RESET    16'h0000
`define PCC_COMPARE_RESET    16'h0000
`define PCC_ZERO_COUNT       16'h0000

`endif
